// [verilog/amt_params.svh]
// constants of the alarm mask and sample trim register bank
// assumes inclusion by bare name from each design file but the flag bank
`ifndef AMT_PARAMS_SVH
`define AMT_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define AMT_IDX_SUMMARY    10'h2C0
`define AMT_IDX_STATUS     10'h2C1
`define AMT_IDX_MASK       10'h2C2
`define AMT_IDX_LANES      10'h2C4
`define AMT_IDX_IRQ_STATUS 10'h2F0
`define AMT_IDX_IRQ_MASK   10'h2F1
`define AMT_IDX_TRIM_A     10'h310
`define AMT_IDX_TRIM_B     10'h313
`define AMT_IDX_TRIM_A_INA 10'h314
`define AMT_IDX_TRIM_B_INA 10'h315

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define AMT_ALARM_W        6
`define AMT_BIT_FIFO       5
`define AMT_TRIM_W         8
`define AMT_TRIM_N         4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AMT_RST_MASK       6'h3F
`define AMT_RST_STATUS     6'h3F
`define AMT_RST_LANES      16'hFFFF
`define AMT_RST_TRIM       8'h00
`define AMT_RST_IRQ_MASK   6'h3F

`endif

// [verilog/amt_pkg.sv]
// types shared by the alarm mask and sample trim register bank
// assumes the params header sits in the include path
`include "amt_params.svh"

package amt_pkg;

	// ----------------------------------------------------------------
	// alarm sources, most significant field is bit 5
	// ----------------------------------------------------------------
	typedef struct packed {
		logic lane_fifo_fault_flag;
		logic lock_loss_flag;
		logic link_fault_flag;
		logic realign_event_flag;
		logic oscillator_phase_fault_flag;
		logic divider_mismatch_flag;
	} amt_alarm_ev_t;

	// ----------------------------------------------------------------
	// trim store: 0 a dual, 1 b dual, 2 a single input_a, 3 b single input_a
	// ----------------------------------------------------------------
	typedef logic [`AMT_TRIM_N-1:0][`AMT_TRIM_W-1:0] amt_trim_set_t;

	typedef enum logic [1:0] {
		AMT_MODE_DUAL,
		AMT_MODE_SINGLE_INA,
		AMT_MODE_SINGLE_INB
	} amt_mode_t;

endpackage

// [verilog/amt_flag_bank.sv]
// sticky flag bank: hardware sets, a clear vector clears, set wins
// assumes set and clear are synchronous to clk
`timescale 1ns/1ps

module amt_flag_bank #(
	parameter int          W     = 16,
	parameter logic [W-1:0] RESET = '1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// flag control
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// flag state
	output logic      [W-1:0] flags
);

	if (W < 1) begin : g_bad_w
		$error("flag bank width must be at least one");
	end

	wire [W-1:0] next_flags = (flags & ~clr) | set;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) flags <= RESET;
		else        flags <= next_flags;
	end

endmodule

// [verilog/amt_trim_sel.sv]
// picks the sample-instant trim of each converter core by mode
// assumes mode is steady while the result is used
`timescale 1ns/1ps
`include "amt_params.svh"

module amt_trim_sel
	import amt_pkg::*;
(
	// selection inputs
	input  wire amt_mode_t              mode,
	input  wire amt_trim_set_t          trims,
	// selected trims
	output logic [`AMT_TRIM_W-1:0]      trim_a,
	output logic [`AMT_TRIM_W-1:0]      trim_b,
	output logic                        served
);

	wire is_dual = (mode == AMT_MODE_DUAL);
	wire is_ina  = (mode == AMT_MODE_SINGLE_INA);

	// input_b trims live outside this bank, so that mode is not served
	assign trim_a = is_dual ? trims[0] : (is_ina ? trims[2] : '0);
	assign trim_b = is_dual ? trims[1] : (is_ina ? trims[3] : '0);
	assign served = is_dual | is_ina;

endmodule

// [verilog/amt_regs.sv]
// alarm mask, per-lane fifo alarm and sample trim registers on apb
// assumes apb3/apb4 master on clk, events and mode synchronous to clk
//
// Notes on behaviour
// - set mask bit hides its alarm from summary
// - mask resets to all six set, reserved zero
// - lane fifo fault sets its lane flag
// - write one clears lane flag; persisting fault resets
// - clearing status fifo bit clears all lanes
// - lane flags reset to all sixteen set
// - trims load factory value, readable and writable
// - held trim sets its core sampling instant
// - trim chosen by core and operating mode
// - summary alarm is any unmasked status bit
`timescale 1ns/1ps
`include "amt_params.svh"

module amt_regs
	import amt_pkg::*;
#(
	parameter int LANES  = 16,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// alarm sources
	input  wire amt_alarm_ev_t          alarm_events,
	input  wire logic [LANES-1:0]       lane_events,
	// factory trim store and mode
	input  wire amt_trim_set_t          fuse_trim,
	input  wire amt_mode_t              mode,
	// results
	output logic                        alarm_out,
	output logic                        irq,
	output logic [`AMT_TRIM_W-1:0]      core_a_trim,
	output logic [`AMT_TRIM_W-1:0]      core_b_trim,
	output logic                        trim_served
);

	if (LANES < 1 || LANES > 16) begin : g_bad_lanes
		$error("lane count must be 1 to 16");
	end
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
		$error("address width must be 12 to 32");
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire [9:0]  idx     = paddr[11:2];
	wire        aligned = (paddr[1:0] == 2'h0) && (paddr >> 12 == '0);
	wire        setup   = psel & ~penable;
	wire        access  = psel & penable & pready;
	wire        wr      = access & pwrite;
	wire        rd      = access & ~pwrite;
	wire [15:0] wm      = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [15:0] wv      = pwdata[15:0] & wm;

	wire hit_sum    = aligned && (idx == `AMT_IDX_SUMMARY);
	wire hit_status = aligned && (idx == `AMT_IDX_STATUS);
	wire hit_mask   = aligned && (idx == `AMT_IDX_MASK);
	wire hit_lanes  = aligned && (idx == `AMT_IDX_LANES);
	wire hit_istat  = aligned && (idx == `AMT_IDX_IRQ_STATUS);
	wire hit_imask  = aligned && (idx == `AMT_IDX_IRQ_MASK);
	wire [3:0] hit_trim = {aligned && (idx == `AMT_IDX_TRIM_B_INA),
	                       aligned && (idx == `AMT_IDX_TRIM_A_INA),
	                       aligned && (idx == `AMT_IDX_TRIM_B),
	                       aligned && (idx == `AMT_IDX_TRIM_A)};
	wire hit_any = hit_sum | hit_status | hit_mask | hit_lanes | hit_istat
	             | hit_imask | (|hit_trim);

	// ----------------------------------------------------------------
	// alarm mask
	// ----------------------------------------------------------------
	logic [`AMT_ALARM_W-1:0] mask;
	wire  [`AMT_ALARM_W-1:0] next_mask = (wr && hit_mask) ?
	        ((mask & ~wm[5:0]) | wv[5:0]) : mask;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) mask <= `AMT_RST_MASK;
		else        mask <= next_mask;
	end

	// ----------------------------------------------------------------
	// alarm status and per-lane fifo flags
	// ----------------------------------------------------------------
	logic [`AMT_ALARM_W-1:0] status;
	logic [LANES-1:0]        lanes;
	wire  [`AMT_ALARM_W-1:0] status_set = alarm_events | {|lane_events, 5'h00};
	wire  [`AMT_ALARM_W-1:0] status_clr = (wr && hit_status) ? wv[5:0] : '0;
	wire                     lanes_all  = status_clr[`AMT_BIT_FIFO];
	// written ones or a status fifo clear clear, written zeros leave the flag alone
	wire  [LANES-1:0] lanes_clr = ((wr && hit_lanes) ? wv[LANES-1:0] : '0)
	                            | {LANES{lanes_all}};

	amt_flag_bank #(
		.W     (`AMT_ALARM_W),
		.RESET (`AMT_RST_STATUS)
	) u_status (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (status_set),
		.clr   (status_clr),
		.flags (status)
	);

	// set wins, so a persisting fault is flagged again at once
	amt_flag_bank #(
		.W     (LANES),
		.RESET (LANES'(`AMT_RST_LANES))
	) u_lanes (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (lane_events),
		.clr   (lanes_clr),
		.flags (lanes)
	);

	// ----------------------------------------------------------------
	// interrupt status (read clears) and mask
	// ----------------------------------------------------------------
	logic [`AMT_ALARM_W-1:0] istat;
	logic [`AMT_ALARM_W-1:0] imask;
	wire  [`AMT_ALARM_W-1:0] istat_set = status_set & ~status;
	wire  [`AMT_ALARM_W-1:0] istat_clr = (rd && hit_istat) ? prdata[5:0] : '0;
	wire  [`AMT_ALARM_W-1:0] next_imask = (wr && hit_imask) ?
	        ((imask & ~wm[5:0]) | wv[5:0]) : imask;

	amt_flag_bank #(
		.W     (`AMT_ALARM_W),
		.RESET ('0)
	) u_istat (
		.clk   (clk),
		.rst_n (rst_n),
		.set   (istat_set),
		.clr   (istat_clr),
		.flags (istat)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) imask <= `AMT_RST_IRQ_MASK;
		else        imask <= next_imask;
	end

	// ----------------------------------------------------------------
	// sample trims, loaded once from the factory store after reset
	// ----------------------------------------------------------------
	amt_trim_set_t trim;
	logic          loaded;
	logic [`AMT_TRIM_W-1:0] sel_a;
	logic [`AMT_TRIM_W-1:0] sel_b;
	logic                   sel_ok;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) loaded <= 1'b0;
		else        loaded <= 1'b1;
	end

	// one register for the whole store keeps each bit on a single driver
	wire amt_trim_set_t next_trims;

	for (genvar k = 0; k < `AMT_TRIM_N; k++) begin : g_trim
		assign next_trims[k] = !loaded ? fuse_trim[k] :
		        ((wr && hit_trim[k] && pstrb[0]) ? pwdata[7:0] : trim[k]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) trim <= {`AMT_TRIM_N{`AMT_RST_TRIM}};
		else        trim <= next_trims;
	end

	amt_trim_sel u_sel (
		.mode   (mode),
		.trims  (trim),
		.trim_a (sel_a),
		.trim_b (sel_b),
		.served (sel_ok)
	);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (hit_sum)          rmux = {31'h0, alarm_out};
		else if (hit_status)  rmux = {26'h0, status};
		else if (hit_mask)    rmux = {26'h0, mask};
		else if (hit_lanes)   rmux = {{(32-LANES){1'b0}}, lanes};
		else if (hit_istat)   rmux = {26'h0, istat};
		else if (hit_imask)   rmux = {26'h0, imask};
		else if (hit_trim[0]) rmux = {24'h0, trim[0]};
		else if (hit_trim[1]) rmux = {24'h0, trim[1]};
		else if (hit_trim[2]) rmux = {24'h0, trim[2]};
		else if (hit_trim[3]) rmux = {24'h0, trim[3]};
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	wire next_alarm = |(status & ~mask);
	wire next_irq   = |(istat & ~imask);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_any;
			if (setup) prdata <= rmux;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_out   <= 1'b0;
			irq         <= 1'b0;
			core_a_trim <= `AMT_RST_TRIM;
			core_b_trim <= `AMT_RST_TRIM;
			trim_served <= 1'b0;
		end else begin
			alarm_out   <= next_alarm;
			irq         <= next_irq;
			core_a_trim <= sel_a;
			core_b_trim <= sel_b;
			trim_served <= sel_ok;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic seen;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) seen <= 1'b0;
		else        seen <= 1'b1;
	end

	reset_values_a: assert property (!seen |-> mask == 6'h3F && lanes == 16'hFFFF)
		else $error("mask or lane flags wrong after reset");
	mask_hides_a: assert property ((status & ~mask) == '0 |=> !alarm_out)
		else $error("masked alarm reached summary");
	summary_alarm_a: assert property (|(status & ~mask) |=> alarm_out)
		else $error("unmasked alarm missing from summary");
	mask_reserved_a: assert property (setup && hit_mask |=> prdata[31:6] == '0)
		else $error("mask reserved bits not zero");
	lane_set_a: assert property (lane_events[0] |=> lanes[0])
		else $error("lane fault did not set flag");
	lane_w1c_a: assert property (wr && hit_lanes && pwdata[0] && pstrb[0] && !lane_events[0]
	                             |=> !lanes[0])
		else $error("lane flag not cleared by write one");
	lane_keep_a: assert property (wr && hit_lanes && !pwdata[0] && !lanes_all
	                              |=> lanes[0] == ($past(lanes[0]) | $past(lane_events[0])))
		else $error("lane flag changed on zero write");
	lane_all_a: assert property (lanes_all && lane_events == '0 |=> lanes == '0)
		else $error("status fifo clear missed lanes");
	trim_load_a: assert property ($rose(loaded) |-> trim == $past(fuse_trim))
		else $error("trims not loaded from factory store");
	trim_dual_a: assert property (mode == AMT_MODE_DUAL ##1 mode == AMT_MODE_DUAL
	                              |-> core_a_trim == $past(trim[0]) && core_b_trim == $past(trim[1]))
		else $error("dual mode trim wrong");
	trim_ina_a: assert property (mode == AMT_MODE_SINGLE_INA
	                             |=> core_a_trim == $past(trim[2]) && core_b_trim == $past(trim[3]))
		else $error("single input_a trim wrong");
	apb_ready_a: assert property (setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
	unmapped_err_a: assert property (setup && !hit_any |=> pslverr && pready && prdata == '0)
		else $error("unmapped access not refused");
	trim_write_a: assert property (wr && hit_trim[0] && pstrb[0] && loaded |=> trim[0] == $past(pwdata[7:0]))
		else $error("trim write lost");
	irq_level_a: assert property (|(istat & ~imask) |=> irq)
		else $error("unmasked interrupt missing");
	irq_masked_a: assert property ((istat & ~imask) == '0 |=> !irq)
		else $error("masked interrupt raised");
	fifo_summary_a: assert property (lane_events != '0 |=> status[`AMT_BIT_FIFO])
		else $error("lane fault missed status fifo bit");

	lane_write_c: cover property (wr && hit_lanes);
	irq_read_c:   cover property (rd && hit_istat && prdata[5:0] != '0);
	alarm_rise_c: cover property ($rose(alarm_out));
	single_ina_c: cover property (mode == AMT_MODE_SINGLE_INA ##1 trim_served);
	lane_all_c:   cover property (lanes_all);

endmodule

// [dv/tb.sv]
// self-checking bench of the alarm mask and sample trim register bank
// assumes the design package, params header and amt_regs are compiled first
`timescale 1ns/1ps
`include "amt_params.svh"

module tb;
	import amt_pkg::*;

	typedef struct packed {
		logic        wr;
		logic [9:0]  idx;
		logic [31:0] data;
	} amt_row_t;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic          clk, rst_n, psel, penable, pwrite;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, rdv;
	logic [3:0]    pstrb;
	logic          pready, pslverr, alarm_out, irq, trim_served, rerr;
	amt_alarm_ev_t alarm_events;
	logic [15:0]   lane_events;
	amt_trim_set_t fuse_trim;
	amt_mode_t     mode;
	logic [7:0]    core_a_trim, core_b_trim;
	logic [7:0]    tr_a [3];
	logic [7:0]    tr_b [3];
	int            err_total, comparisons, cycles;
	amt_row_t      rows [20];

	amt_regs i_amt_regs (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alarm_events(alarm_events), .lane_events(lane_events),
		.fuse_trim(fuse_trim), .mode(mode), .alarm_out(alarm_out), .irq(irq),
		.core_a_trim(core_a_trim), .core_b_trim(core_b_trim), .trim_served(trim_served)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_pin(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one apb transfer; entered and left just after a rising edge
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] off);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, off};
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv     = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 4'hF, 2'b00);
	endtask

	task automatic rd(input logic [9:0] idx);
		apb(1'b0, idx, 32'h0, 4'hF, 2'b00);
	endtask

	// one-cycle event, then time for flags and the alarm outputs to settle
	task automatic pulse(input logic [5:0] ev, input logic [15:0] ln);
		alarm_events <= ev;
		lane_events  <= ln;
		@(posedge clk);
		alarm_events <= '0;
		lane_events  <= '0;
		repeat (3) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		alarm_events = '0;
		lane_events = '0;
		fuse_trim = {8'h44, 8'h33, 8'h22, 8'h11};
		mode = AMT_MODE_DUAL;
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		tr_a = '{8'hA5, 8'hC3, 8'h00};
		tr_b = '{8'h5A, 8'h3C, 8'h00};
		rows = '{'{1'b0, `AMT_IDX_MASK, 32'h3F}, '{1'b0, `AMT_IDX_LANES, 32'hFFFF},
			'{1'b0, `AMT_IDX_STATUS, 32'h3F}, '{1'b0, `AMT_IDX_IRQ_MASK, 32'h3F},
			'{1'b0, `AMT_IDX_IRQ_STATUS, 32'h0}, '{1'b0, `AMT_IDX_SUMMARY, 32'h0},
			'{1'b0, `AMT_IDX_TRIM_A, 32'h11}, '{1'b0, `AMT_IDX_TRIM_B, 32'h22},
			'{1'b0, `AMT_IDX_TRIM_A_INA, 32'h33}, '{1'b0, `AMT_IDX_TRIM_B_INA, 32'h44},
			'{1'b1, `AMT_IDX_MASK, 32'hFF}, '{1'b0, `AMT_IDX_MASK, 32'h3F},
			'{1'b1, `AMT_IDX_TRIM_A, 32'hA5}, '{1'b1, `AMT_IDX_TRIM_B, 32'h5A},
			'{1'b1, `AMT_IDX_TRIM_A_INA, 32'hC3}, '{1'b1, `AMT_IDX_TRIM_B_INA, 32'h3C},
			'{1'b0, `AMT_IDX_TRIM_A, 32'hA5}, '{1'b0, `AMT_IDX_TRIM_B, 32'h5A},
			'{1'b0, `AMT_IDX_TRIM_A_INA, 32'hC3}, '{1'b0, `AMT_IDX_TRIM_B_INA, 32'h3C}};
		repeat (10) @(posedge clk);
		chk_pin("pready in reset", 1'b0, pready);
		chk_pin("irq in reset", 1'b0, irq);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].idx, rows[i].data);
			end else begin
				rd(rows[i].idx);
				chk("row read", rows[i].data, rdv);
			end
		end
		for (int m = 0; m < 3; m++) begin
			mode <= amt_mode_t'(m);
			repeat (3) @(posedge clk);
			chk("core a trim", {24'h0, tr_a[m]}, {24'h0, core_a_trim});
			chk("core b trim", {24'h0, tr_b[m]}, {24'h0, core_b_trim});
			chk_pin("trim served", m != 2, trim_served);
		end
		mode <= AMT_MODE_DUAL;
		wr(`AMT_IDX_STATUS, 32'h3F);
		for (int i = 0; i < 6; i++) begin
			wr(`AMT_IDX_MASK, 32'h3F ^ (32'h1 << i));
			pulse(6'h01 << ((i + 1) % 6), '0);
			chk_pin("masked alarm", 1'b0, alarm_out);
			pulse(6'h01 << i, '0);
			chk_pin("unmasked alarm", 1'b1, alarm_out);
			wr(`AMT_IDX_STATUS, 32'h3F);
		end
		// interrupt: raise, read-clear, then masked
		rd(`AMT_IDX_IRQ_STATUS);
		wr(`AMT_IDX_IRQ_MASK, 32'h3E);
		pulse(6'h01, '0);
		chk_pin("irq raised", 1'b1, irq);
		rd(`AMT_IDX_IRQ_STATUS);
		chk("irq status", 32'h01, rdv);
		@(posedge clk);
		chk_pin("irq cleared", 1'b0, irq);
		wr(`AMT_IDX_IRQ_MASK, 32'h3F);
		wr(`AMT_IDX_STATUS, 32'h3F);
		pulse(6'h01, '0);
		chk_pin("irq masked", 1'b0, irq);
		rd(`AMT_IDX_IRQ_STATUS);
		chk("masked irq status", 32'h01, rdv);
		// per-lane fifo flags
		wr(`AMT_IDX_LANES, 32'hFFFF);
		rd(`AMT_IDX_LANES);
		chk("lanes cleared", 32'h0, rdv);
		pulse('0, 16'h0008);
		rd(`AMT_IDX_LANES);
		chk("lane set", 32'h8, rdv);
		wr(`AMT_IDX_LANES, 32'h0);
		rd(`AMT_IDX_LANES);
		chk("zero write", 32'h8, rdv);
		lane_events <= 16'h0008;
		wr(`AMT_IDX_LANES, 32'h8);
		rd(`AMT_IDX_LANES);
		chk("persisting fault", 32'h8, rdv);
		lane_events <= '0;
		wr(`AMT_IDX_LANES, 32'h8);
		rd(`AMT_IDX_LANES);
		chk("lane write one", 32'h0, rdv);
		pulse('0, 16'h0202);
		wr(`AMT_IDX_STATUS, 32'h20);
		rd(`AMT_IDX_LANES);
		chk("status fifo clear", 32'h0, rdv);
		pulse('0, 16'h0202);
		apb(1'b1, `AMT_IDX_LANES, 32'hFFFF, 4'h1, 2'b00);
		rd(`AMT_IDX_LANES);
		chk("low byte strobe", 32'h0200, rdv);
		// refused accesses
		apb(1'b0, 10'h3FF, 32'h0, 4'hF, 2'b00);
		chk_pin("unmapped error", 1'b1, rerr);
		chk("unmapped data", 32'h0, rdv);
		apb(1'b1, `AMT_IDX_MASK, 32'h0, 4'hF, 2'b10);
		chk_pin("unaligned error", 1'b1, rerr);
		rd(`AMT_IDX_MASK);
		chk("mask kept", 32'h1F, rdv);
		// second reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`AMT_IDX_MASK);
		chk("mask after reset", 32'h3F, rdv);
		rd(`AMT_IDX_LANES);
		chk("lanes after reset", 32'hFFFF, rdv);
		rd(`AMT_IDX_TRIM_A);
		chk("trim reload", 32'h11, rdv);
		final_report();
	end
endmodule
